// [src/cis_regs.svh]
`ifndef CIS_REGS_SVH
`define CIS_REGS_SVH
// Summary of operation
// - the starved bit (bit 3 of the converter error register) shows that the converter clock is too slow.
// - the left clip bit (bit 2) sets on a left clip and holds until the converter error register is read.
// - the right clip bit (bit 1) sets on a right clip and holds until the converter error register is read.
// - the fast-mode click bit (bit 0) follows fast mode and after a read interrupts again only on a change.
// - left clip, right clip and click bits interrupt only with their enable bit at 1; starved has none.
// - summary bit 7 sets while any enabled converter error is pending and holds until the status read.
// - bit 6 sets when the host writes the transmit status buffer during its copy to the transmit buffer.
// - bit 5 sets when the transmit buffer is empty and holds until the status register is read.
// - bit 4 sets when the transmit status buffer has sent its block and holds until read.
// - bit 3 sets when the A and B status blocks differ, holds until read and never interrupts.
// - bit 2 sets when the receive user-bit buffer holds a new block and holds until read.
// - bit 1 sets on each new status block with change select 0, or only on a change with it at 1.
// - bit 0 sets while any enabled receiver error is asserted and holds until the status read.
// - each status bit interrupts only with its enable bit at 1; the enable position of bit 3 is reserved.
// - a receiver error flag feeds the receive error summary only with its enable bit at 1.

`define CIS_ADDR_SRC_ERR 7'h1a
`define CIS_ADDR_SRC_EN 7'h1b
`define CIS_ADDR_INT_STAT 7'h1c
`define CIS_ADDR_INT_EN 7'h1d

`define CIS_SRC_STARVED_BIT 3
`define CIS_SRC_CLIP_L_BIT 2
`define CIS_SRC_CLIP_R_BIT 1
`define CIS_SRC_CLICK_BIT 0
`define CIS_SRC_FOLLOW 4'h9

`define CIS_INT_SRC_BIT 7
`define CIS_INT_COLL_BIT 6
`define CIS_INT_TXEMPTY_BIT 5
`define CIS_INT_TXSENT_BIT 4
`define CIS_INT_ABDIFF_BIT 3
`define CIS_INT_RXUSER_BIT 2
`define CIS_INT_RXCS_BIT 1
`define CIS_INT_RXERR_BIT 0

`define CIS_SRC_EN_WRITABLE 8'h07
`define CIS_INT_EN_WRITABLE 8'hf7
`define CIS_REG_RESET 8'h00
`define CIS_FLAG_RESET 1'b0
`define CIS_SPI_LAST_BIT 3'h7
`define CIS_SPI_READ 1'b1
`endif

// [src/cis_pkg.sv]
package cis_pkg;
  typedef enum logic [1:0] {
    SPI_ADDR,
    SPI_DATA,
    SPI_DONE
  } cis_spi_state_type;
  typedef logic [7:0] cis_byte_type;
  typedef logic [6:0] cis_addr_type;
endpackage

// [src/cis_flag_bank.sv]
`include "cis_regs.svh"
module cis_flag_bank #(
  parameter int WIDTH = 8
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] sticky_set,
  input wire logic [WIDTH-1:0] level_in,
  input wire logic [WIDTH-1:0] follow_sel,
  input wire logic rd_clear,
  output logic [WIDTH-1:0] flag_reg,
  output logic [WIDTH-1:0] pending_reg
);
  // ****************************************************************
  // per-bit flag: sticky (set wins over read clear) or level-following
  // ****************************************************************
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
          flag_reg[i] <= `CIS_FLAG_RESET;
        end else if (follow_sel[i]) begin
          flag_reg[i] <= level_in[i];
        end else if (sticky_set[i]) begin
          flag_reg[i] <= 1'b1;
        end else if (rd_clear) begin
          flag_reg[i] <= 1'b0;
        end
      end
      // a following bit interrupts once per change, a read only acknowledges it
      always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
          pending_reg[i] <= `CIS_FLAG_RESET;
        end else if (follow_sel[i]) begin
          if (level_in[i] != flag_reg[i]) begin
            pending_reg[i] <= 1'b1;
          end else if (rd_clear) begin
            pending_reg[i] <= 1'b0;
          end
        end else if (sticky_set[i]) begin
          pending_reg[i] <= 1'b1;
        end else if (rd_clear) begin
          pending_reg[i] <= 1'b0;
        end
      end
    end
  endgenerate
endmodule // cis_flag_bank

// [src/cis_spi_slave.sv]
`include "cis_regs.svh"
module cis_spi_slave (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ctl_clk,
  input wire logic ctl_data_in,
  input wire logic ctl_latch_b,
  output logic ctl_data_out,
  output logic rd_req,
  output logic wr_req,
  output cis_pkg::cis_addr_type addr_reg,
  output cis_pkg::cis_byte_type wdata_reg,
  input wire cis_pkg::cis_byte_type rd_data
);
  import cis_pkg::*;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic clk_s1, clk_s2, clk_s3, dat_s1, dat_s2, lat_b_s1, lat_b_s2;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      clk_s1 <= 1'b0;
      clk_s2 <= 1'b0;
      clk_s3 <= 1'b0;
      dat_s1 <= 1'b0;
      dat_s2 <= 1'b0;
      lat_b_s1 <= 1'b1;
      lat_b_s2 <= 1'b1;
    end else begin
      clk_s1 <= ctl_clk;
      clk_s2 <= clk_s1;
      clk_s3 <= clk_s2;
      dat_s1 <= ctl_data_in;
      dat_s2 <= dat_s1;
      lat_b_s1 <= ctl_latch_b;
      lat_b_s2 <= lat_b_s1;
    end
  end
  logic rise, fall;
  assign rise = clk_s2 & ~clk_s3;
  assign fall = ~clk_s2 & clk_s3;

  // ****************************************************************
  // frame: 7 address bits, read/write bit, 8 data bits, msb first
  // ****************************************************************
  cis_spi_state_type state_reg;
  logic [2:0] cnt_reg;
  logic [6:0] shift_reg;
  logic rw_reg;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= SPI_ADDR;
      cnt_reg <= 3'h0;
      shift_reg <= 7'h00;
      rw_reg <= 1'b0;
      addr_reg <= 7'h00;
      wdata_reg <= 8'h00;
      rd_req <= 1'b0;
      wr_req <= 1'b0;
    end else begin
      rd_req <= 1'b0;
      wr_req <= 1'b0;
      if (lat_b_s2) begin
        state_reg <= SPI_ADDR;
        cnt_reg <= 3'h0;
      end else if (rise) begin
        shift_reg <= {shift_reg[5:0], dat_s2};
        cnt_reg <= cnt_reg + 3'h1;
        case (state_reg)
          SPI_ADDR: begin
            if (cnt_reg == `CIS_SPI_LAST_BIT) begin
              addr_reg <= shift_reg;
              rw_reg <= dat_s2;
              rd_req <= (dat_s2 == `CIS_SPI_READ);
              state_reg <= SPI_DATA;
            end
          end
          SPI_DATA: begin
            if (cnt_reg == `CIS_SPI_LAST_BIT) begin
              wdata_reg <= {shift_reg, dat_s2};
              wr_req <= (rw_reg != `CIS_SPI_READ);
              state_reg <= SPI_DONE;
            end
          end
          SPI_DONE: begin
            cnt_reg <= cnt_reg;
          end
          default: begin
            state_reg <= SPI_ADDR;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // read data leaves on falling edges so the host samples on rising
  // ****************************************************************
  logic [7:0] out_shift_reg;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      out_shift_reg <= 8'h00;
    end else if (rd_req) begin
      out_shift_reg <= rd_data;
    end else if (fall && state_reg == SPI_DATA) begin
      out_shift_reg <= {out_shift_reg[6:0], 1'b0};
    end
  end
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ctl_data_out <= 1'b0;
    end else if (lat_b_s2) begin
      ctl_data_out <= 1'b0;
    end else if (fall && state_reg == SPI_DATA && rw_reg == `CIS_SPI_READ) begin
      ctl_data_out <= out_shift_reg[7];
    end
  end
endmodule // cis_spi_slave

// [src/cis_top.sv]
`include "cis_regs.svh"
module cis_top (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ctl_clk,
  input wire logic ctl_data_in,
  input wire logic ctl_latch_b,
  output logic ctl_data_out,
  input wire logic src_too_slow,
  input wire logic src_clip_left,
  input wire logic src_clip_right,
  input wire logic src_fast_mode,
  input wire logic tx_cs_write_collision,
  input wire logic tx_buffer_empty,
  input wire logic tx_cs_block_done,
  input wire logic rx_cs_ab_differ,
  input wire logic rx_user_block_new,
  input wire logic rx_cs_block_new,
  input wire logic rx_cs_changed,
  input wire logic rx_status_change_select,
  input wire cis_pkg::cis_byte_type rx_error_flags,
  input wire cis_pkg::cis_byte_type rx_error_enables,
  output logic irq_req,
  output logic rate_conv_mute_hint
);
  import cis_pkg::*;

  // ****************************************************************
  // serial control port
  // ****************************************************************
  logic rd_req, wr_req;
  cis_addr_type addr;
  cis_byte_type wdata, rd_data;
  cis_spi_slave u_spi (
    .mclk(mclk),
    .rst_b(rst_b),
    .ctl_clk(ctl_clk),
    .ctl_data_in(ctl_data_in),
    .ctl_latch_b(ctl_latch_b),
    .ctl_data_out(ctl_data_out),
    .rd_req(rd_req),
    .wr_req(wr_req),
    .addr_reg(addr),
    .wdata_reg(wdata),
    .rd_data(rd_data)
  );

  // ****************************************************************
  // enable (mask) registers
  // ****************************************************************
  cis_byte_type rate_conv_error_enables_reg, interrupt_summary_enables_reg;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rate_conv_error_enables_reg <= `CIS_REG_RESET;
    end else if (wr_req && addr == `CIS_ADDR_SRC_EN) begin
      // starved bit has no enable position
      rate_conv_error_enables_reg <= wdata & `CIS_SRC_EN_WRITABLE;
    end
  end
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      interrupt_summary_enables_reg <= `CIS_REG_RESET;
    end else if (wr_req && addr == `CIS_ADDR_INT_EN) begin
      // mismatch enable position stays reserved at zero
      interrupt_summary_enables_reg <= wdata & `CIS_INT_EN_WRITABLE;
    end
  end

  // ****************************************************************
  // converter error flags
  // ****************************************************************
  logic [3:0] src_set, src_level, src_flag, src_pend;
  logic src_rd_clear, src_irq;
  assign src_rd_clear = rd_req && addr == `CIS_ADDR_SRC_ERR;
  always_comb begin
    src_set = 4'h0;
    src_level = 4'h0;
    src_level[`CIS_SRC_STARVED_BIT] = src_too_slow;
    src_set[`CIS_SRC_CLIP_L_BIT] = src_clip_left;
    src_set[`CIS_SRC_CLIP_R_BIT] = src_clip_right;
    src_level[`CIS_SRC_CLICK_BIT] = src_fast_mode;
  end
  cis_flag_bank #(.WIDTH(4)) u_src_flags (
    .mclk(mclk),
    .rst_b(rst_b),
    .sticky_set(src_set),
    .level_in(src_level),
    .follow_sel(`CIS_SRC_FOLLOW),
    .rd_clear(src_rd_clear),
    .flag_reg(src_flag),
    .pending_reg(src_pend)
  );
  // a following bit only counts while its change is unacknowledged
  assign src_irq = |(src_pend[2:0] & rate_conv_error_enables_reg[2:0]);

  // ****************************************************************
  // interrupt status flags
  // ****************************************************************
  cis_byte_type int_set, int_flag, rx_err_enabled;
  logic int_rd_clear;
  assign int_rd_clear = rd_req && addr == `CIS_ADDR_INT_STAT;
  assign rx_err_enabled = rx_error_flags & rx_error_enables;
  always_comb begin
    int_set = 8'h00;
    // set while the cause persists, so a read cannot hide an open converter error
    int_set[`CIS_INT_SRC_BIT] = src_irq;
    int_set[`CIS_INT_COLL_BIT] = tx_cs_write_collision;
    int_set[`CIS_INT_TXEMPTY_BIT] = tx_buffer_empty;
    int_set[`CIS_INT_TXSENT_BIT] = tx_cs_block_done;
    int_set[`CIS_INT_ABDIFF_BIT] = rx_cs_ab_differ;
    int_set[`CIS_INT_RXUSER_BIT] = rx_user_block_new;
    int_set[`CIS_INT_RXCS_BIT] = rx_status_change_select ? rx_cs_changed
                                                         : rx_cs_block_new;
    int_set[`CIS_INT_RXERR_BIT] = |rx_err_enabled;
  end
  cis_flag_bank #(.WIDTH(8)) u_int_flags (
    .mclk(mclk),
    .rst_b(rst_b),
    .sticky_set(int_set),
    .level_in(8'h00),
    .follow_sel(8'h00),
    .rd_clear(int_rd_clear),
    .flag_reg(int_flag),
    .pending_reg()
  );

  // ****************************************************************
  // interrupt request and outputs
  // ****************************************************************
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      irq_req <= 1'b0;
    end else begin
      // writable mask excludes the mismatch bit
      irq_req <= |(int_flag & interrupt_summary_enables_reg & `CIS_INT_EN_WRITABLE);
    end
  end
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rate_conv_mute_hint <= 1'b0;
    end else begin
      rate_conv_mute_hint <= src_flag[`CIS_SRC_CLICK_BIT];
    end
  end

  // ****************************************************************
  // read back; addresses outside this block read zero
  // ****************************************************************
  always_comb begin
    case (addr)
      `CIS_ADDR_SRC_ERR: rd_data = {4'h0, src_flag};
      `CIS_ADDR_SRC_EN: rd_data = rate_conv_error_enables_reg;
      `CIS_ADDR_INT_STAT: rd_data = int_flag;
      `CIS_ADDR_INT_EN: rd_data = interrupt_summary_enables_reg;
      default: rd_data = 8'h00;
    endcase
  end
endmodule // cis_top

// [tb/cis_top_assertions.sv]
module cis_top_assertions (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ctl_clk,
  input wire logic ctl_latch_b,
  input wire logic ctl_data_out,
  input wire logic src_clip_left,
  input wire logic src_clip_right,
  input wire logic src_fast_mode,
  input wire logic tx_cs_write_collision,
  input wire logic tx_buffer_empty,
  input wire logic tx_cs_block_done,
  input wire logic rx_user_block_new,
  input wire logic rx_cs_block_new,
  input wire logic rx_cs_changed,
  input wire cis_pkg::cis_byte_type rx_error_flags,
  input wire cis_pkg::cis_byte_type rx_error_enables,
  input wire logic irq_req,
  input wire logic rate_conv_mute_hint
);
  timeunit 1ns;
  timeprecision 1ps;
  import cis_pkg::*;
  // **********
  // helper counters
  // **********
  logic [7:0] act_cnt;
  logic [7:0] frame_cnt;
  logic [1:0] run_cnt;
  logic fast_prev;
  logic act;
  // starved and a/b mismatch are left out on purpose: they must never interrupt
  assign act = src_clip_left | src_clip_right | (src_fast_mode != fast_prev)
    | tx_cs_write_collision | tx_buffer_empty | tx_cs_block_done | rx_user_block_new
    | rx_cs_block_new | rx_cs_changed | (|(rx_error_flags & rx_error_enables)) | !ctl_latch_b;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      act_cnt <= 8'h00;
      frame_cnt <= 8'h00;
      run_cnt <= 2'h0;
      fast_prev <= 1'b0;
    end else begin
      act_cnt <= act ? 8'h00 : act_cnt + {7'h00, act_cnt != 8'hff};
      frame_cnt <= !ctl_latch_b ? 8'h00 : frame_cnt + {7'h00, frame_cnt != 8'hff};
      run_cnt <= run_cnt + {1'b0, run_cnt != 2'h3};
      fast_prev <= src_fast_mode;
    end
  end
  // **********
  // properties
  // **********
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence latch_idle;
    ctl_latch_b [*8];
  endsequence
  sequence clk_steady;
    (ctl_clk && !ctl_latch_b) [*5];
  endsequence
  reset_values_a: assert property (disable iff (1'b0) !rst_b |->
    !irq_req && !ctl_data_out && !rate_conv_mute_hint) else $error("outputs not cleared");
  idle_line_a: assert property (latch_idle |-> !ctl_data_out)
    else $error("read line not low between frames");
  out_steady_a: assert property (clk_steady |=> $stable(ctl_data_out))
    else $error("read line moved while serial clock high");
  mute_follow_a: assert property (run_cnt == 2'h3 |->
    rate_conv_mute_hint == $past(src_fast_mode, 2)) else $error("mute hint lags fast mode");
  irq_cause_a: assert property ($rose(irq_req) |-> act_cnt <= 8'h10)
    else $error("irq rose with no enabled cause");
  irq_hold_a: assert property ($fell(irq_req) |-> frame_cnt <= 8'h10)
    else $error("irq fell without a register access");
  out_in_frame_a: assert property ($rose(ctl_data_out) |-> frame_cnt <= 8'h02)
    else $error("read data outside a frame");
  irq_quiet_a: assert property (act_cnt > 8'h14 && frame_cnt > 8'h14 |=> $stable(irq_req))
    else $error("irq moved while all quiet");
endmodule // cis_top_assertions

bind cis_top cis_top_assertions u_chk (.*);

// [tb/cis_top_tb.sv]
module cis_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cis_pkg::*;
  logic mclk = 1, rst_b = 1, ctl_clk = 0, ctl_data_in = 0, ctl_latch_b = 1;
  logic too_slow = 0, clip_l = 0, clip_r = 0, fast = 0, sel = 0;
  logic [6:0] cz = 7'h00;
  cis_byte_type err_f = 8'h00, err_e = 8'h00, rv;
  logic ctl_data_out, irq_req, mute_hint;
  int n_errors = 0, samples_checked = 0;
  always #12.5 mclk = ~mclk;
  cis_top dut (.mclk(mclk), .rst_b(rst_b), .ctl_clk(ctl_clk), .ctl_data_in(ctl_data_in),
    .ctl_latch_b(ctl_latch_b), .ctl_data_out(ctl_data_out), .src_too_slow(too_slow),
    .src_clip_left(clip_l), .src_clip_right(clip_r), .src_fast_mode(fast),
    .tx_cs_write_collision(cz[6]), .tx_buffer_empty(cz[5]), .tx_cs_block_done(cz[4]),
    .rx_cs_ab_differ(cz[3]), .rx_user_block_new(cz[2]), .rx_cs_block_new(cz[1]),
    .rx_cs_changed(cz[0]), .rx_status_change_select(sel), .rx_error_flags(err_f),
    .rx_error_enables(err_e), .irq_req(irq_req), .rate_conv_mute_hint(mute_hint));
  // **********
  // access tasks
  // **********
  task automatic check(input cis_byte_type got, input cis_byte_type exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // half periods of 6 mclk leave room for the 3-flop clock sync and the 2-flop data and latch syncs
  task automatic xfer(input logic rd_n, input cis_addr_type a, input cis_byte_type wd);
    logic [15:0] f;
    f = {a, rd_n, wd};
    @(negedge mclk) ctl_latch_b = 0;
    repeat (6) @(negedge mclk);
    for (int i = 15; i >= 0; i--) begin
      ctl_data_in = f[i];
      repeat (6) @(negedge mclk);
      if (i < 8) rv[i] = ctl_data_out;
      ctl_clk = 1;
      repeat (6) @(negedge mclk);
      ctl_clk = 0;
    end
    repeat (6) @(negedge mclk);
    ctl_latch_b = 1;
    repeat (8) @(negedge mclk);
  endtask
  task automatic wr(input cis_addr_type a, input cis_byte_type d);
    xfer(1'b0, a, d);
  endtask
  task automatic rd(input cis_addr_type a, input cis_byte_type exp);
    xfer(1'b1, a, 8'h00);
    check(rv, exp);
  endtask
  task automatic irq(input logic exp);
    repeat (4) @(negedge mclk);
    check({7'h00, irq_req}, {7'h00, exp});
  endtask
  task automatic pulse(input int b);
    cz[b] = 1;
    @(negedge mclk);
    cz[b] = 0;
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // **********
  // tests
  // **********
  initial begin
    // a real falling edge on reset before the first rising clock edge
    @(negedge mclk);
    rst_b = 0;
    repeat (3) @(negedge mclk);
    rst_b = 1;
    repeat (4) @(negedge mclk);
    for (int a = 8'h1a; a <= 8'h1d; a++) rd(a[6:0], 8'h00);
    rd(7'h7f, 8'h00);
    wr(7'h1a, 8'hff);
    rd(7'h1a, 8'h00);
    wr(7'h1b, 8'hff);
    rd(7'h1b, 8'h07);
    wr(7'h1d, 8'hff);
    rd(7'h1d, 8'hf7);
    $display("test registers done");
    clip_l = 1;
    @(negedge mclk);
    clip_l = 0;
    irq(1);
    rd(7'h1a, 8'h04);
    rd(7'h1a, 8'h00);
    irq(1);
    rd(7'h1c, 8'h80);
    irq(0);
    wr(7'h1b, 8'h05);
    clip_r = 1;
    @(negedge mclk);
    clip_r = 0;
    irq(0);
    rd(7'h1a, 8'h02);
    rd(7'h1c, 8'h00);
    too_slow = 1;
    irq(0);
    rd(7'h1a, 8'h08);
    rd(7'h1c, 8'h00);
    too_slow = 0;
    $display("test converter flags done");
    fast = 1;
    irq(1);
    // a long quiet stretch: the request must hold with no new cause
    repeat (30) @(negedge mclk);
    irq(1);
    check({7'h00, mute_hint}, 8'h01);
    rd(7'h1a, 8'h01);
    rd(7'h1c, 8'h80);
    irq(0);
    rd(7'h1a, 8'h01);
    fast = 0;
    irq(1);
    rd(7'h1a, 8'h00);
    rd(7'h1c, 8'h80);
    irq(0);
    $display("test click done");
    for (int b = 6; b >= 1; b--) begin
      wr(7'h1d, 8'h01 << b);
      pulse(b);
      irq(b != 3);
      rd(7'h1c, 8'h01 << b);
      rd(7'h1c, 8'h00);
    end
    sel = 1;
    pulse(1);
    rd(7'h1c, 8'h00);
    pulse(0);
    rd(7'h1c, 8'h02);
    sel = 0;
    pulse(0);
    rd(7'h1c, 8'h00);
    $display("test status causes done");
    wr(7'h1d, 8'h01);
    err_f = 8'h04;
    irq(0);
    rd(7'h1c, 8'h00);
    err_e = 8'h04;
    irq(1);
    err_f = 8'h00;
    irq(1);
    rd(7'h1c, 8'h01);
    rd(7'h1c, 8'h00);
    irq(0);
    $display("test receiver summary done");
    complete_run;
  end
  // about four times the expected run length
  initial begin
    repeat (40000) @(posedge mclk);
    n_errors++;
    complete_run;
  end
endmodule // cis_top_tb
